// [core/pin_filter.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pin_filter #(
    parameter int WIDTH = 7
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    filter_if.filter port
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_filter needs WIDTH of at least one");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] clean;
    wire logic [WIDTH-1:0] next_clean;

    // Take stage two only where it agrees with stage three
    assign next_clean = (stage2 & stage3) | (clean & (stage2 ^ stage3));
    assign port.clean = clean;

    // Synchroniser chain and filtered level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            clean <= '0;
        end else begin
            stage1 <= port.raw;
            stage2 <= stage1;
            stage3 <= stage2;
            clean <= next_clean;
        end
    end
endmodule

`default_nettype wire

// [core/status_bank.sv]
// Event, line and interface status register bank
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Event flags latch on their event and hold until read.
// - Any read of the event flags clears all of them.
// - Bit 7 flags that power was cycled since the last read.
// - Event bits 6, 3 and 1 always read zero.
// - Bit 5 sets when a command could not be understood.
// - Bit 4 sets when a command could not be carried out.
// - Bit 2 sets on empty output queue read or lost response.
// - Bit 0 sets when pending operations finish after completion command.
// - Eight-bit event mask; summary set when flag and mask bit coincide.
// - Line live state shows seven indicators; bit 7 reads zero.
// - Line gain bits record indicators gained since last read; bit 7 zero.
// - Line drop bits record losses of bits 3 to 0; upper bits zero.
// - Line summary set by enabled gain bit or enabled drop bit.
// - Both line masks can be read back as well as written.
// - Interface bits show active signals; bits 7 and 6 read zero.
// - Bits 5 and 4 follow the switches chosen by emulation mode.
// - Bits 3 to 0 mirror high leads chosen by emulation mode.
// - Event summary goes to summary bit 5, line summary to bit 2.
// - Gain on off-to-on change, drop on on-to-off change.
// - Reading gain or drop records clears them.
module status_bank
    import status_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic command_error_in,
    input wire logic execution_error_in,
    input wire logic query_error_in,
    input wire logic operation_done_in,
    input wire logic dce_mode,
    input wire logic test_complete_ind,
    input wire logic inverted_rx_clock_ind,
    input wire logic inverted_rx_data_ind,
    input wire logic generator_clock_ind,
    input wire logic pattern_sync_ind,
    input wire logic frame_sync_ind,
    input wire logic signal_present_ind,
    input wire logic dsr_switch,
    input wire logic dtr_switch,
    input wire logic rlsd_switch,
    input wire logic rts_switch,
    input wire logic rl_lead,
    input wire logic ll_lead,
    input wire logic dtr_lead,
    input wire logic rts_lead,
    input wire logic tm_lead,
    input wire logic cts_lead,
    input wire logic dsr_lead,
    input wire logic rlsd_lead,
    input wire logic query_valid,
    input wire logic [2:0] query_sel,
    input wire logic write_valid,
    input wire logic [2:0] write_sel,
    input wire logic [7:0] write_data,
    output logic reply_valid,
    output logic [7:0] reply_data,
    output logic event_summary_bit,
    output logic line_summary_bit,
    output logic [7:0] status_summary
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] event_flags;
    logic [7:0] event_flag_mask;
    logic [LINE_W-1:0] line_prev;
    logic [LINE_W-1:0] line_gain_record;
    logic [7:0] line_gain_mask;
    logic [DROP_W-1:0] line_drop_record;
    logic [7:0] line_drop_mask;

    // ----------------------------------------------------------------
    // Pin filters for line indicators and interface sources
    // ----------------------------------------------------------------
    filter_if #(.WIDTH(LINE_W)) line_port ();
    filter_if #(.WIDTH(LEAD_W)) lead_port ();

    // Line indicators in register order, bit 6 down to bit 0
    assign line_port.raw = {test_complete_ind, inverted_rx_clock_ind,
        inverted_rx_data_ind, generator_clock_ind, pattern_sync_ind,
        frame_sync_ind, signal_present_ind};

    // Emulation mode picks switch and lead sources
    assign lead_port.raw = dce_mode ?
        {dsr_switch, rlsd_switch, rl_lead, ll_lead, dtr_lead, rts_lead} :
        {dtr_switch, rts_switch, tm_lead, cts_lead, dsr_lead, rlsd_lead};

    pin_filter #(.WIDTH(LINE_W)) line_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(line_port)
    );

    pin_filter #(.WIDTH(LEAD_W)) lead_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(lead_port)
    );

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    wire reg_sel_e rd_sel = reg_sel_e'(query_sel);
    wire reg_sel_e wr_sel = reg_sel_e'(write_sel);
    wire logic rd_event = query_valid && (rd_sel == SEL_EVENT_FLAGS);
    wire logic rd_gain = query_valid && (rd_sel == SEL_LINE_GAIN);
    wire logic rd_drop = query_valid && (rd_sel == SEL_LINE_DROP);
    wire logic wr_event_mask = write_valid && (wr_sel == SEL_EVENT_MASK);
    wire logic wr_gain_mask = write_valid && (wr_sel == SEL_GAIN_MASK);
    wire logic wr_drop_mask = write_valid && (wr_sel == SEL_DROP_MASK);

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    wire logic [7:0] event_set;
    wire logic [7:0] event_keep;
    wire logic [7:0] next_event;

    // Incoming events placed at their bit positions
    assign event_set = (8'(command_error_in) << EV_CMD_BIT)
        | (8'(execution_error_in) << EV_EXEC_BIT)
        | (8'(query_error_in) << EV_QUERY_BIT)
        | (8'(operation_done_in) << EV_OPC_BIT);

    // Read clears all, new events still land
    assign event_keep = rd_event ? 8'h00 : event_flags;
    assign next_event = (event_keep | event_set) & EVENT_USED;

    // ----------------------------------------------------------------
    // Line gain and drop records
    // ----------------------------------------------------------------
    wire logic [LINE_W-1:0] line_live = line_port.clean;
    wire logic [LINE_W-1:0] line_rise = line_live & ~line_prev;
    wire logic [LINE_W-1:0] line_fall = line_prev & ~line_live;
    wire logic [LINE_W-1:0] next_gain;
    wire logic [DROP_W-1:0] next_drop;

    // Sticky edges, cleared by reads, set wins over clear
    assign next_gain = (rd_gain ? '0 : line_gain_record) | line_rise;
    assign next_drop = (rd_drop ? '0 : line_drop_record)
        | line_fall[DROP_W-1:0];

    // ----------------------------------------------------------------
    // Summaries
    // ----------------------------------------------------------------
    wire logic event_hit = |(event_flags & event_flag_mask);
    wire logic gain_hit = |(line_gain_record & line_gain_mask[LINE_W-1:0]);
    wire logic drop_hit = |(line_drop_record & line_drop_mask[DROP_W-1:0]);
    wire logic line_hit = gain_hit | drop_hit;
    wire logic [7:0] next_summary = (8'(event_hit) << SB_EVENT_BIT)
        | (8'(line_hit) << SB_LINE_BIT);

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    // Every source is an argument so the assignment follows all of them
    function automatic logic [7:0] read_view(
        input reg_sel_e sel,
        input logic [7:0] ev,
        input logic [7:0] ev_mask,
        input logic [7:0] live,
        input logic [7:0] gain,
        input logic [7:0] gain_mask,
        input logic [7:0] drop,
        input logic [7:0] drop_mask,
        input logic [7:0] lead
    );
        logic [7:0] view;
        view = 8'h00;
        unique case (sel)
            SEL_EVENT_FLAGS: view = ev;
            SEL_EVENT_MASK: view = ev_mask;
            SEL_LINE_LIVE: view = live;
            SEL_LINE_GAIN: view = gain;
            SEL_GAIN_MASK: view = gain_mask;
            SEL_LINE_DROP: view = drop;
            SEL_DROP_MASK: view = drop_mask;
            SEL_LEAD_LIVE: view = lead;
        endcase
        return view;
    endfunction

    wire logic [7:0] next_reply = read_view(rd_sel, event_flags, event_flag_mask, 8'(line_live),
        8'(line_gain_record), line_gain_mask, 8'(line_drop_record), line_drop_mask,
        8'(lead_port.clean) & LEAD_USED);

    // ----------------------------------------------------------------
    // Event and mask registers
    // ----------------------------------------------------------------
    // Power-up leaves the power-cycled flag set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_flags <= EVENT_RESET;
            event_flag_mask <= MASK_RESET;
            line_gain_mask <= MASK_RESET;
            line_drop_mask <= MASK_RESET;
        end else begin
            event_flags <= next_event;
            if (wr_event_mask) begin
                event_flag_mask <= write_data;
            end
            if (wr_gain_mask) begin
                line_gain_mask <= write_data;
            end
            if (wr_drop_mask) begin
                line_drop_mask <= write_data;
            end
        end
    end

    // Line edge tracking
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_prev <= '0;
            line_gain_record <= '0;
            line_drop_record <= '0;
        end else begin
            line_prev <= line_live;
            line_gain_record <= next_gain;
            line_drop_record <= next_drop;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reply_valid <= 1'b0;
            reply_data <= 8'h00;
            event_summary_bit <= 1'b0;
            line_summary_bit <= 1'b0;
            status_summary <= 8'h00;
        end else begin
            reply_valid <= query_valid;
            reply_data <= query_valid ? next_reply : 8'h00;
            event_summary_bit <= event_hit;
            line_summary_bit <= line_hit;
            status_summary <= next_summary;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_event_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (event_flags[EV_POWER_BIT] && !rd_event) |=> event_flags[EV_POWER_BIT])
        else $error("Event flag dropped without a read");

    a_read_clears_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_event && event_set == 8'h00) |=> event_flags == 8'h00)
        else $error("Event flags survived a read");

    a_power_flag_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_event && event_flags[EV_POWER_BIT]) |=> reply_data[EV_POWER_BIT])
        else $error("Power flag not reported");

    a_unused_event_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        event_flags[EV_USER_BIT] == 1'b0 && event_flags[EV_DEVICE_BIT] == 1'b0
        && event_flags[EV_REQ_BIT] == 1'b0)
        else $error("Unused event bit set");

    a_cmd_err_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (command_error_in && rd_event) |=> event_flags[EV_CMD_BIT])
        else $error("Command error lost");

    a_exec_err_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        execution_error_in |=> event_flags[EV_EXEC_BIT])
        else $error("Execution error lost");

    a_query_err_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        query_error_in |=> event_flags[EV_QUERY_BIT])
        else $error("Query error lost");

    a_opc_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        operation_done_in |=> event_flags[EV_OPC_BIT])
        else $error("Operation complete lost");

    a_event_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 (event_summary_bit == |($past(event_flags) & $past(event_flag_mask))
        && status_summary[SB_EVENT_BIT] == event_summary_bit))
        else $error("Event summary mismatch");

    a_line_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 (status_summary[SB_LINE_BIT] == line_summary_bit))
        else $error("Line summary not in summary byte");

    a_gain_on_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (line_live[0] && !line_prev[0]) |=> line_gain_record[0])
        else $error("Gain edge missed");

    a_drop_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!line_live[0] && line_prev[0]) |=> line_drop_record[0])
        else $error("Drop edge missed");

    a_gain_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_gain && line_rise == '0) |=> line_gain_record == '0)
        else $error("Gain record survived a read");

    a_drop_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_drop && line_fall[DROP_W-1:0] == '0) |=> line_drop_record == '0)
        else $error("Drop record survived a read");

    a_mask_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (query_valid && rd_sel == SEL_GAIN_MASK) |=> reply_data == $past(line_gain_mask))
        else $error("Gain mask readback wrong");

    a_lead_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (query_valid && rd_sel == SEL_LEAD_LIVE) |=> reply_data[7:6] == 2'b00)
        else $error("Interface upper bits not zero");

    a_line_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (query_valid && rd_sel == SEL_LINE_LIVE) |=> reply_data[7] == 1'b0)
        else $error("Line bit 7 not zero");

endmodule

`default_nettype wire

// [inc/filter_if.sv]
// Carrier between the bank and its pin filter
`timescale 1ns/100ps
`default_nettype none

interface filter_if #(parameter int WIDTH = 7);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;

    modport filter (input raw, output clean);
    modport user (output raw, input clean);
endinterface

`default_nettype wire

// [inc/status_pkg.sv]
// Shared constants for the status and summary register bank
package status_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int LINE_W = 7;
    localparam int DROP_W = 4;
    localparam int LEAD_W = 6;

    // ----------------------------------------------------------------
    // Register selection on the query and write ports
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_EVENT_FLAGS,
        SEL_EVENT_MASK,
        SEL_LINE_LIVE,
        SEL_LINE_GAIN,
        SEL_GAIN_MASK,
        SEL_LINE_DROP,
        SEL_DROP_MASK,
        SEL_LEAD_LIVE
    } reg_sel_e;

    // ----------------------------------------------------------------
    // Event flag bit positions
    // ----------------------------------------------------------------
    localparam int EV_POWER_BIT = 7;
    localparam int EV_USER_BIT = 6;
    localparam int EV_CMD_BIT = 5;
    localparam int EV_EXEC_BIT = 4;
    localparam int EV_DEVICE_BIT = 3;
    localparam int EV_QUERY_BIT = 2;
    localparam int EV_REQ_BIT = 1;
    localparam int EV_OPC_BIT = 0;

    // ----------------------------------------------------------------
    // Used-bit masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] EVENT_USED = 8'hB5;
    localparam logic [7:0] EVENT_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LEAD_USED = 8'h3F;

    // ----------------------------------------------------------------
    // Summary byte bit positions
    // ----------------------------------------------------------------
    localparam int SB_EVENT_BIT = 5;
    localparam int SB_LINE_BIT = 2;

endpackage

// [testbench/test_status_bank.sv]
// Self-checking testbench for the status and summary register bank
`timescale 1ns/100ps
`default_nettype none

module test_status_bank;
    import status_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] ev_in = 4'h0; // Command, execution, query, completion
    logic dce_mode = 1'h1;
    logic [6:0] line_pins = 7'h00;
    logic [5:0] dce_src = 6'h00;
    logic [5:0] dte_src = 6'h00;
    logic query_valid = 1'h0;
    logic [2:0] query_sel = 3'h0;
    logic write_valid = 1'h0;
    logic [2:0] write_sel = 3'h0;
    logic [7:0] write_data = 8'h00;
    logic reply_valid;
    logic [7:0] reply_data;
    logic event_summary_bit;
    logic line_summary_bit;
    logic [7:0] status_summary;
    logic [7:0] got;
    int err_total = 0;
    int tests_run = 0;

    // Clock at 40 MHz
    always #12.5 sys_clk = ~sys_clk;

    status_bank dut (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .command_error_in(ev_in[3]), .execution_error_in(ev_in[2]),
        .query_error_in(ev_in[1]), .operation_done_in(ev_in[0]), .dce_mode(dce_mode),
        .test_complete_ind(line_pins[6]), .inverted_rx_clock_ind(line_pins[5]),
        .inverted_rx_data_ind(line_pins[4]), .generator_clock_ind(line_pins[3]),
        .pattern_sync_ind(line_pins[2]), .frame_sync_ind(line_pins[1]),
        .signal_present_ind(line_pins[0]),
        .dsr_switch(dce_src[5]), .rlsd_switch(dce_src[4]), .rl_lead(dce_src[3]),
        .ll_lead(dce_src[2]), .dtr_lead(dce_src[1]), .rts_lead(dce_src[0]),
        .dtr_switch(dte_src[5]), .rts_switch(dte_src[4]), .tm_lead(dte_src[3]),
        .cts_lead(dte_src[2]), .dsr_lead(dte_src[1]), .rlsd_lead(dte_src[0]),
        .query_valid(query_valid), .query_sel(query_sel), .write_valid(write_valid),
        .write_sel(write_sel), .write_data(write_data), .reply_valid(reply_valid),
        .reply_data(reply_data), .event_summary_bit(event_summary_bit),
        .line_summary_bit(line_summary_bit), .status_summary(status_summary)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One query; reply stands for the one cycle after the edge that takes it
    task automatic rd(input reg_sel_e sel, output logic [7:0] val);
        @(posedge sys_clk);
        query_valid <= 1'h1;
        query_sel <= sel;
        @(posedge sys_clk);
        query_valid <= 1'h0;
        #1;
        check({7'h00, reply_valid}, 8'h01);
        val = reply_data;
    endtask

    task automatic rd_check(input reg_sel_e sel, input logic [7:0] exp);
        rd(sel, got);
        check(got, exp);
    endtask

    task automatic wr(input reg_sel_e sel, input logic [7:0] data);
        @(posedge sys_clk);
        write_valid <= 1'h1;
        write_sel <= sel;
        write_data <= data;
        @(posedge sys_clk);
        write_valid <= 1'h0;
    endtask

    // Pin change on a clock edge, then time to pass the filter and edge logic
    task automatic set_pins(input logic [6:0] v);
        @(posedge sys_clk);
        line_pins <= v;
        wait_cyc(8);
    endtask

    // One-cycle pulse on the chosen event inputs
    task automatic fire(input logic [3:0] ev);
        @(posedge sys_clk);
        ev_in <= ev;
        @(posedge sys_clk);
        ev_in <= 4'h0;
        wait_cyc(2);
    endtask

    task automatic summaries(input logic ev_bit, input logic ln_bit);
        check({7'h00, event_summary_bit}, {7'h00, ev_bit});
        check({7'h00, line_summary_bit}, {7'h00, ln_bit});
        check(status_summary, {2'h0, ev_bit, 2'h0, ln_bit, 2'h0});
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Power flag after reset, then each event alone, then all together
    task automatic event_flags_test;
        logic [7:0] exp_tab [4];
        exp_tab = '{8'h01, 8'h04, 8'h10, 8'h20};
        check(status_summary, 8'h00);
        rd_check(SEL_EVENT_FLAGS, 8'h80);
        rd_check(SEL_EVENT_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            fire(4'h1 << i);
            wait_cyc(4);
            rd_check(SEL_EVENT_FLAGS, exp_tab[i]);
            rd_check(SEL_EVENT_FLAGS, 8'h00);
        end
        fire(4'hF);
        rd_check(SEL_EVENT_FLAGS, 8'h35);
    endtask

    // Event mask drives the summary; a clearing read drops it
    task automatic event_summary_test;
        rd_check(SEL_EVENT_MASK, 8'h00);
        wr(SEL_EVENT_FLAGS, 8'hFF);
        rd_check(SEL_EVENT_FLAGS, 8'h00);
        fire(4'hF);
        wr(SEL_EVENT_MASK, 8'hCA);
        wait_cyc(3);
        summaries(1'h0, 1'h0);
        wr(SEL_EVENT_MASK, 8'h20);
        wait_cyc(3);
        summaries(1'h1, 1'h0);
        rd_check(SEL_EVENT_MASK, 8'h20);
        rd_check(SEL_EVENT_FLAGS, 8'h35);
        wait_cyc(3);
        summaries(1'h0, 1'h0);
    endtask

    // An event in the same cycle as the clearing read survives
    task automatic set_wins_test;
        fire(4'h8);
        @(posedge sys_clk);
        query_valid <= 1'h1;
        query_sel <= SEL_EVENT_FLAGS;
        ev_in <= 4'h4;
        @(posedge sys_clk);
        query_valid <= 1'h0;
        ev_in <= 4'h0;
        #1;
        check(reply_data, 8'h20);
        rd_check(SEL_EVENT_FLAGS, 8'h10);
    endtask

    // Live line state, gain and drop records, line summary
    task automatic line_test;
        set_pins(7'h55);
        rd_check(SEL_LINE_LIVE, 8'h55);
        rd_check(SEL_LINE_GAIN, 8'h55);
        rd_check(SEL_LINE_GAIN, 8'h00);
        rd_check(SEL_LINE_DROP, 8'h00);
        set_pins(7'h00);
        rd_check(SEL_LINE_LIVE, 8'h00);
        rd_check(SEL_LINE_DROP, 8'h05);
        rd_check(SEL_LINE_DROP, 8'h00);
        rd_check(SEL_LINE_GAIN, 8'h00);
        wr(SEL_GAIN_MASK, 8'h80);
        wr(SEL_DROP_MASK, 8'hF0);
        set_pins(7'h7F);
        set_pins(7'h00);
        summaries(1'h0, 1'h0);
        rd_check(SEL_GAIN_MASK, 8'h80);
        rd_check(SEL_DROP_MASK, 8'hF0);
        wr(SEL_DROP_MASK, 8'h08);
        wait_cyc(3);
        summaries(1'h0, 1'h1);
        rd_check(SEL_LINE_DROP, 8'h0F);
        wait_cyc(3);
        summaries(1'h0, 1'h0);
        wr(SEL_GAIN_MASK, 8'h40);
        wait_cyc(3);
        summaries(1'h0, 1'h1);
        rd_check(SEL_LINE_GAIN, 8'h7F);
        wait_cyc(3);
        summaries(1'h0, 1'h0);
    endtask

    // Interface bits follow the sources chosen by the emulation mode
    task automatic lead_test;
        logic [12:0] tab [5];
        tab = '{{1'h1, 6'h2D, 6'h12}, {1'h0, 6'h2D, 6'h12}, {1'h0, 6'h00, 6'h3F},
                {1'h1, 6'h00, 6'h3F}, {1'h1, 6'h3F, 6'h00}};
        foreach (tab[i]) begin
            @(posedge sys_clk);
            dce_mode <= tab[i][12];
            dce_src <= tab[i][11:6];
            dte_src <= tab[i][5:0];
            wait_cyc(8);
            rd(SEL_LEAD_LIVE, got);
            check(got, {2'h0, tab[i][12] ? tab[i][11:6] : tab[i][5:0]});
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'h1;
        wait_cyc(1);
        event_flags_test();
        event_summary_test();
        set_wins_test();
        line_test();
        lead_test();
        wrap_up();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(25 * 5000);
        err_total++;
        wrap_up();
    end
endmodule

`default_nettype wire
